// ==== design/iper_top.v ====
// interrupt priority register and extended enable register, with the
// request masking and level tagging presented to the processor core
// assumes: same-clock pending flags, an 8-bit special-function bus,
// the global enable and basic enables live in another register,
// as do the extended priorities; flags arrive already synchronised
// to clk_i, so they feed the mask logic with no extra stages;
// results reach the core one clock after the inputs, but req_o, level_o and the choice lag register writes by two
//
// Notes on behaviour
// R1: unused priority bit 7 always reads one; writes to it are dropped.
// R2: priority bit 6 sets SPI port 0 level; one is high.
// R3: priority bit 5 sets timer 2 level; one is high.
// R4: priority bit 4 sets UART level; one is high.
// R5: priority bit 3 sets timer 1 level; one is high.
// R6: priority bit 2 sets external interrupt 1 level; one is high.
// R7: priority bit 1 sets timer 0 level; one is high.
// R8: priority bit 0 cleared puts external interrupt 0 at low level.
// R9: priority bit 0 set puts external interrupt 0 at high level.
// R10: priority register at 0xB8, page 0 only, with single-bit writes.
// R11: enable bit 7 passes timer 3 low or high overflow requests.
// R12: enable bit 6 passes comparator 1 rising or falling requests.
// R13: enable bit 5 passes comparator 0 rising or falling requests.
// R14: enable bit 4 passes every counter array request.
// R15: enable bit 3 passes the conversion done request.
// R16: enable bit 2 passes the converter window request.
// R17: enable bit 1 passes real-time-clock alarm requests.
// R18: enable bit 0 passes every two-wire port request.
// R19: enable register at 0xE6 on all pages, read/write, reset to zero.
// R20: global enable low blocks all sources; high defers to each mask.
// R21: request shown only while flag and enable set, tagged with its level.
// R22: pending high-level requests are picked before low-level ones.
`timescale 1ns/1ns
`include "iper_regs.vh"

module iper_top (
  input  wire                     clk_i,
  input  wire                     nrst_i,
  // special-function register port
  input  wire [7:0]               sfr_addr_i,
  input  wire [7:0]               sfr_page_i,
  input  wire                     sfr_wr_i,
  input  wire [7:0]               sfr_wdata_i,
  input  wire                     sfr_bit_wr_i,
  input  wire [2:0]               sfr_bit_sel_i,
  input  wire                     sfr_bit_val_i,
  input  wire                     sfr_rd_i,
  output reg  [7:0]               sfr_rdata_o,
  // enables and priorities held elsewhere
  input  wire                     global_int_enable_i,
  input  wire [6:0]               basic_int_enable_i,
  input  wire [7:0]               ext_priority_i,
  // basic source pending flags
  input  wire                     ext_int0_flag_i,
  input  wire                     timer0_flag_i,
  input  wire                     ext_int1_flag_i,
  input  wire                     timer1_flag_i,
  input  wire                     uart_flag_i,
  input  wire                     timer2_flag_i,
  input  wire                     spi_port0_flag_i,
  // extended source pending flags
  input  wire                     two_wire_port_flag_i,
  input  wire                     rtc_alarm_flag_i,
  input  wire                     converter_window_flag_i,
  input  wire                     conversion_done_flag_i,
  input  wire                     counter_array_flag_i,
  input  wire                     comparator0_rising_flag_i,
  input  wire                     comparator0_falling_flag_i,
  input  wire                     comparator1_rising_flag_i,
  input  wire                     comparator1_falling_flag_i,
  input  wire                     timer3_low_overflow_flag_i,
  input  wire                     timer3_high_overflow_flag_i,
  // register contents for the core
  output reg  [7:0]               basic_interrupt_priority_o,
  output reg  [7:0]               extended_interrupt_enable_one_o,
  // requests toward the core
  output reg  [`IPER_NUM_SRC-1:0] req_o,
  output reg  [`IPER_NUM_SRC-1:0] level_o,
  output reg                      sel_valid_o,
  output reg  [`IPER_IDX_W-1:0]   sel_index_o,
  output reg                      sel_high_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte write into a register with some bits held
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    begin
      merge_byte = (old_val & ~wmask) | (new_val & wmask);
    end
  endfunction

  // single-bit write, as a bit-addressed set or clear
  function [7:0] merge_bit;
    input [7:0] old_val;
    input [2:0] sel;
    input       val;
    input [7:0] wmask;
    reg   [7:0] onehot;
    begin
      onehot    = 8'h01 << sel;
      onehot    = onehot & wmask;
      merge_bit = (old_val & ~onehot) | ({8{val}} & onehot);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg  [6:0] prio_bits;   // writable part of the priority register
  reg  [7:0] xen_bits;    // extended enable register
  reg  [7:0] next_prio;
  reg  [7:0] next_xen;
  wire [7:0] prio_view;   // priority register as software sees it

  // reset image of the stored bits; bit 7 is not stored
  localparam [7:0] PRIO_RST = `IPER_PRIO_RESET & `IPER_PRIO_WMASK;

  // bit 7 has no storage so it cannot drift from its fixed value
  assign prio_view = {1'b1, prio_bits}; // R1

  ////////////////////////////////////////////////////////////////////////
  // address decode

  wire hit_prio;
  wire hit_xen;

  // priority register only answers on page zero
  assign hit_prio = (sfr_addr_i == `IPER_PRIO_ADDR) &&
                    (sfr_page_i == `IPER_PRIO_PAGE); // R10
  // extended enable ignores the page
  assign hit_xen = (sfr_addr_i == `IPER_XEN_ADDR); // R19

  ////////////////////////////////////////////////////////////////////////
  // decoded strobes

  wire wr_prio_byte;      // byte write to the priority register
  wire wr_prio_bit;       // single-bit write to the priority register
  wire wr_xen_byte;       // byte write to the enable register
  wire rd_prio;           // read of the priority register
  wire rd_xen;            // read of the enable register

  // a strobe with no address hit does nothing, so stray cycles on
  // the shared bus cannot disturb either register
  assign wr_prio_byte = hit_prio & sfr_wr_i; // R10
  assign wr_prio_bit  = hit_prio & sfr_bit_wr_i; // R10
  assign wr_xen_byte  = hit_xen & sfr_wr_i; // R19
  assign rd_prio      = hit_prio & sfr_rd_i; // R10
  assign rd_xen       = hit_xen & sfr_rd_i; // R19

  ////////////////////////////////////////////////////////////////////////
  // next register values

  // byte writes win over bit writes if both arrive together
  always @* begin
    next_prio = prio_view;
    if (wr_prio_byte) begin
      next_prio = merge_byte(prio_view, sfr_wdata_i,
                             `IPER_PRIO_WMASK); // R1
    end else if (wr_prio_bit) begin
      next_prio = merge_bit(prio_view, sfr_bit_sel_i,
                            sfr_bit_val_i, `IPER_PRIO_WMASK); // R10
    end
  end

  // not bit-addressable, so bit writes to it are ignored
  always @* begin
    next_xen = xen_bits;
    if (wr_xen_byte) begin
      next_xen = sfr_wdata_i; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage

  // priority storage; only bits 6 to 0 exist
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_bits <= PRIO_RST[6:0];
    end else begin
      prio_bits <= next_prio[6:0];
    end
  end

  // enable storage; every bit cleared by reset
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xen_bits <= `IPER_XEN_RESET; // R19
    end else begin
      xen_bits <= next_xen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  reg [7:0] next_rdata;

  // unmapped or idle reads give zero; a read in the write cycle
  // returns the old contents
  always @* begin
    next_rdata = 8'h00;
    if (rd_prio) begin
      next_rdata = prio_view; // R1
    end else if (rd_xen) begin
      next_rdata = xen_bits; // R19
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-source pending flags; several flags share one request line

  wire [`IPER_NUM_SRC-1:0] pend;

  assign pend[0]  = ext_int0_flag_i;
  assign pend[1]  = timer0_flag_i;
  assign pend[2]  = ext_int1_flag_i;
  assign pend[3]  = timer1_flag_i;
  assign pend[4]  = uart_flag_i;
  assign pend[5]  = timer2_flag_i;
  assign pend[6]  = spi_port0_flag_i;

  // extended sources; comparator and timer 3 pairs share a line
  assign pend[7]  = two_wire_port_flag_i; // R18
  assign pend[8]  = rtc_alarm_flag_i; // R17
  assign pend[9]  = converter_window_flag_i; // R16
  assign pend[10] = conversion_done_flag_i; // R15
  assign pend[11] = counter_array_flag_i; // R14
  assign pend[12] = comparator0_rising_flag_i |
                    comparator0_falling_flag_i; // R13
  assign pend[13] = comparator1_rising_flag_i |
                    comparator1_falling_flag_i; // R12
  assign pend[14] = timer3_low_overflow_flag_i |
                    timer3_high_overflow_flag_i; // R11

  ////////////////////////////////////////////////////////////////////////
  // per-source enable bits

  wire [`IPER_NUM_SRC-1:0] en;

  // basic enables come from the register outside this block
  assign en[6:0] = basic_int_enable_i;

  // extended enables come from the local register
  assign en[7]   = xen_bits[`IPER_TWP_EN_BIT]; // R18
  assign en[8]   = xen_bits[`IPER_RTC_EN_BIT]; // R17
  assign en[9]   = xen_bits[`IPER_WIN_EN_BIT]; // R16
  assign en[10]  = xen_bits[`IPER_EOC_EN_BIT]; // R15
  assign en[11]  = xen_bits[`IPER_PCA_EN_BIT]; // R14
  assign en[12]  = xen_bits[`IPER_CMP0_EN_BIT]; // R13
  assign en[13]  = xen_bits[`IPER_CMP1_EN_BIT]; // R12
  assign en[14]  = xen_bits[`IPER_TMR3_EN_BIT]; // R11

  ////////////////////////////////////////////////////////////////////////
  // per-source priority levels; one means high

  wire [`IPER_NUM_SRC-1:0] lvl;

  assign lvl[0]  = prio_bits[`IPER_EXT0_PRI_BIT]; // R8 R9
  assign lvl[1]  = prio_bits[`IPER_TMR0_PRI_BIT]; // R7
  assign lvl[2]  = prio_bits[`IPER_EXT1_PRI_BIT]; // R6
  assign lvl[3]  = prio_bits[`IPER_TMR1_PRI_BIT]; // R5
  assign lvl[4]  = prio_bits[`IPER_UART_PRI_BIT]; // R4
  assign lvl[5]  = prio_bits[`IPER_TMR2_PRI_BIT]; // R3
  assign lvl[6]  = prio_bits[`IPER_SPI0_PRI_BIT]; // R2

  // extended levels are held in a register outside this block
  assign lvl[14:7] = ext_priority_i;

  ////////////////////////////////////////////////////////////////////////
  // masking

  wire [`IPER_NUM_SRC-1:0] next_req;

  // global enable overrides every individual mask
  assign next_req = pend & en &
                    {`IPER_NUM_SRC{global_int_enable_i}}; // R20 R21

  ////////////////////////////////////////////////////////////////////////
  // selection among live requests

  wire                    pick_valid;
  wire [`IPER_IDX_W-1:0]  pick_index;
  wire                    pick_high;

  // picks from the same values that land in req_o, so the choice
  // and the request lines always agree in a given cycle
  iper_pick u_pick (
    .req_i   (next_req),
    .level_i (lvl),
    .valid_o (pick_valid),
    .index_o (pick_index),
    .high_o  (pick_high)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered outputs; one cycle of latency from flag to request

  // requests and levels toward the core
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_o       <= {`IPER_NUM_SRC{1'b0}};
      level_o     <= {`IPER_NUM_SRC{1'b0}};
    end else begin
      req_o       <= next_req; // R21
      level_o     <= lvl; // R21
    end
  end

  // choice registered beside the requests, so the two stay in step
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_valid_o <= 1'b0;
      sel_index_o <= `IPER_IDX_NONE;
      sel_high_o  <= 1'b0;
    end else begin
      sel_valid_o <= pick_valid;
      sel_index_o <= pick_index; // R22
      sel_high_o  <= pick_high; // R22
    end
  end

  // register copies for the core; priority shows bit 7 as one
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      basic_interrupt_priority_o      <= `IPER_PRIO_RESET;
      extended_interrupt_enable_one_o <= `IPER_XEN_RESET;
    end else begin
      basic_interrupt_priority_o      <= next_prio; // R1
      extended_interrupt_enable_one_o <= next_xen;
    end
  end

endmodule // iper_top

// ==== design/iper_regs.vh ====
// constants for the interrupt priority / extended enable register pair
// assumes an 8-bit special-function bus with page select and bit access
`ifndef IPER_REGS_VH
`define IPER_REGS_VH

// addresses and pages
`define IPER_PRIO_ADDR       8'hB8
`define IPER_PRIO_PAGE       8'h00
`define IPER_XEN_ADDR        8'hE6

// reset values; the unused priority bit reads one
`define IPER_PRIO_RESET      8'h80
`define IPER_XEN_RESET       8'h00
`define IPER_PRIO_UNUSED_BIT 7
`define IPER_PRIO_WMASK      8'h7F

// priority register fields
`define IPER_EXT0_PRI_BIT    0
`define IPER_TMR0_PRI_BIT    1
`define IPER_EXT1_PRI_BIT    2
`define IPER_TMR1_PRI_BIT    3
`define IPER_UART_PRI_BIT    4
`define IPER_TMR2_PRI_BIT    5
`define IPER_SPI0_PRI_BIT    6

// extended enable register fields
`define IPER_TWP_EN_BIT      0
`define IPER_RTC_EN_BIT      1
`define IPER_WIN_EN_BIT      2
`define IPER_EOC_EN_BIT      3
`define IPER_PCA_EN_BIT      4
`define IPER_CMP0_EN_BIT     5
`define IPER_CMP1_EN_BIT     6
`define IPER_TMR3_EN_BIT     7

// source numbering: basic sources 0..6, extended sources 7..14
`define IPER_NUM_SRC         15
`define IPER_NUM_BASIC       7
`define IPER_IDX_W           4
`define IPER_IDX_NONE        4'hF

`endif

// ==== design/iper_pick.v ====
// selector: picks the next request to service from a request vector
// assumes req and level settle within one cycle, ahead of the caller's output flip-flops
`timescale 1ns/1ns
`include "iper_regs.vh"

module iper_pick (
  input  wire [`IPER_NUM_SRC-1:0] req_i,
  input  wire [`IPER_NUM_SRC-1:0] level_i,
  output reg                      valid_o,
  output reg  [`IPER_IDX_W-1:0]   index_o,
  output reg                      high_o
);

  integer i;
  reg     hi_found;
  reg     lo_found;
  reg [`IPER_IDX_W-1:0] hi_idx;
  reg [`IPER_IDX_W-1:0] lo_idx;

  ////////////////////////////////////////////////////////////////////////
  // walk downward so the lowest number wins within a level
  always @* begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_idx   = `IPER_IDX_NONE;
    lo_idx   = `IPER_IDX_NONE;
    for (i = `IPER_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (req_i[i] && level_i[i]) begin
        hi_found = 1'b1;
        hi_idx   = i[`IPER_IDX_W-1:0];
      end
      if (req_i[i] && !level_i[i]) begin
        lo_found = 1'b1;
        lo_idx   = i[`IPER_IDX_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // any high request beats every low request
  always @* begin
    valid_o = hi_found | lo_found;
    high_o  = hi_found; // R22
    if (hi_found) begin
      index_o = hi_idx; // R22
    end else begin
      index_o = lo_idx;
    end
  end

endmodule // iper_pick

// ==== tb/iper_checker.sv ====
// checker: register and request relations at the ports of iper_top
// assumes it is bound onto iper_top; one clock, async active-low reset
`timescale 1ns/1ns
module iper_checker (
  input wire        clk_i,
  input wire        nrst_i,
  input wire [7:0]  sfr_addr_i,
  input wire [7:0]  sfr_page_i,
  input wire        sfr_wr_i,
  input wire [7:0]  sfr_wdata_i,
  input wire        sfr_rd_i,
  input wire        global_int_enable_i,
  input wire        timer3_low_overflow_flag_i,
  input wire [7:0]  sfr_rdata_o,
  input wire [7:0]  basic_interrupt_priority_o,
  input wire [7:0]  extended_interrupt_enable_one_o,
  input wire [14:0] req_o,
  input wire [14:0] level_o,
  input wire        sel_valid_o,
  input wire [3:0]  sel_index_o,
  input wire        sel_high_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // short views; the priority hit needs page zero, the enable any page
  wire [7:0] pri = basic_interrupt_priority_o;
  wire [7:0] eie = extended_interrupt_enable_one_o;
  wire       hit = sfr_addr_i == 8'hB8 && sfr_page_i == 8'h00;
  // two steady cycles make the check blind to which register copy is used
  sequence t3_live;
    global_int_enable_i && eie[7] && timer3_low_overflow_flag_i;
  endsequence
  sequence t3_shut;
    !eie[7];
  endsequence
  //////////////////////////////////////////////////////////////////////
  top_one_a: assert property (pri[7])
    else $error("priority top bit not one");
  prio_write_a: assert property (sfr_wr_i && hit |=>
    pri[6:0] == $past(sfr_wdata_i[6:0])) else $error("priority write lost");
  enable_write_a: assert property (sfr_wr_i && sfr_addr_i == 8'hE6 |=>
    eie == $past(sfr_wdata_i)) else $error("enable write lost");
  enable_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hE6 |=>
    sfr_rdata_o == $past(eie)) else $error("enable read wrong");
  level_mirror_a: assert property ($stable(pri) |->
    level_o[6:0] == pri[6:0]) else $error("basic level differs");
  gate_off_a: assert property (!global_int_enable_i |=>
    req_o == 15'h0 && !sel_valid_o) else $error("request while off");
  timer3_pass_a: assert property (t3_live ##1 t3_live |-> req_o[14])
    else $error("timer3 request lost");
  timer3_mask_a: assert property (t3_shut ##1 t3_shut |-> !req_o[14])
    else $error("timer3 request leaked");
  sel_valid_a: assert property (sel_valid_o == (|req_o))
    else $error("select valid wrong");
  sel_pick_a: assert property (sel_valid_o |-> req_o[sel_index_o] &&
    level_o[sel_index_o] == sel_high_o) else $error("select tag wrong");
  high_first_a: assert property (sel_valid_o && !sel_high_o |->
    (req_o & level_o) == 15'h0) else $error("low chosen over high");
endmodule // iper_checker

bind iper_top iper_checker iper_checker_inst (.clk_i, .nrst_i, .sfr_addr_i,
  .sfr_page_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .global_int_enable_i,
  .timer3_low_overflow_flag_i, .sfr_rdata_o, .basic_interrupt_priority_o,
  .extended_interrupt_enable_one_o, .req_o, .level_o, .sel_valid_o,
  .sel_index_o, .sel_high_o);

// ==== tb/iper_src_model.sv ====
// peripheral side: pending flags of the fifteen sources as levels
// assumes the bench changes pend_i and alt_i off the rising edge
`timescale 1ns/1ns
module iper_src_model (
  input  wire [14:0] pend_i,
  input  wire        alt_i,
  output wire [17:0] flag_o
);
  // single-flag sources hold their flag until software clears it
  assign flag_o[11:0] = pend_i[11:0];
  // paired sources raise one flag alone, so each OR input is seen singly
  assign flag_o[12] = pend_i[12] & ~alt_i;
  assign flag_o[13] = pend_i[12] & alt_i;
  assign flag_o[14] = pend_i[13] & ~alt_i;
  assign flag_o[15] = pend_i[13] & alt_i;
  assign flag_o[16] = pend_i[14] & ~alt_i;
  assign flag_o[17] = pend_i[14] & alt_i;
endmodule // iper_src_model

// ==== tb/testbench.sv ====
// self-checking bench for iper_top with the peripheral flag model
// assumes inputs move on the falling edge, outputs one cycle behind
`timescale 1ns/1ns
module testbench;
  reg         clk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [7:0]  adr = 8'h00, pg = 8'h00, wd = 8'h00, epri = 8'h00;
  reg         wr = 1'b0, bwr = 1'b0, bval = 1'b0, rd = 1'b0;
  reg         glob = 1'b0, alt = 1'b0;
  reg  [2:0]  bsel = 3'h0;
  reg  [6:0]  ben = 7'h00;
  reg  [14:0] pend = 15'h0;
  wire [17:0] fl;
  wire [7:0]  rdat, pri, eie;
  wire [14:0] req, lvl;
  wire        sv, sh;
  wire [3:0]  si;
  integer     num_errors = 0, checked = 0, k, a;
  always #5 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////
  iper_src_model iper_src_model_inst (.pend_i(pend), .alt_i(alt),
    .flag_o(fl));
  iper_top iper_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .sfr_addr_i(adr), .sfr_page_i(pg), .sfr_wr_i(wr), .sfr_wdata_i(wd),
    .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
    .sfr_rd_i(rd), .sfr_rdata_o(rdat), .global_int_enable_i(glob),
    .basic_int_enable_i(ben), .ext_priority_i(epri),
    .ext_int0_flag_i(fl[0]), .timer0_flag_i(fl[1]),
    .ext_int1_flag_i(fl[2]), .timer1_flag_i(fl[3]), .uart_flag_i(fl[4]),
    .timer2_flag_i(fl[5]), .spi_port0_flag_i(fl[6]),
    .two_wire_port_flag_i(fl[7]), .rtc_alarm_flag_i(fl[8]),
    .converter_window_flag_i(fl[9]), .conversion_done_flag_i(fl[10]),
    .counter_array_flag_i(fl[11]), .comparator0_rising_flag_i(fl[12]),
    .comparator0_falling_flag_i(fl[13]),
    .comparator1_rising_flag_i(fl[14]),
    .comparator1_falling_flag_i(fl[15]),
    .timer3_low_overflow_flag_i(fl[16]),
    .timer3_high_overflow_flag_i(fl[17]),
    .basic_interrupt_priority_o(pri),
    .extended_interrupt_enable_one_o(eie), .req_o(req), .level_o(lvl),
    .sel_valid_o(sv), .sel_index_o(si), .sel_high_o(sh));
  //////////////////////////////////////////////////////////////////////
  // every result fits 15 bits, so one compare serves all
  task chk(input [14:0] got, input [14:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // bus tasks start and end on a falling edge; strobes last one cycle;
  // reads and bit writes end with an idle cycle so strobes never retoggle
  task wrb(input [7:0] a_, input [7:0] p_, input [7:0] d_);
    begin
      adr = a_;
      pg = p_;
      wd = d_;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
    end
  endtask
  task rdb(input [7:0] a_, input [7:0] p_, input [7:0] e_);
    begin
      adr = a_;
      pg = p_;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      chk({7'h0, rdat}, {7'h0, e_});
      @(negedge clk_i);
    end
  endtask
  task bitw(input [2:0] s_, input v_);
    begin
      adr = 8'hB8;
      pg = 8'h00;
      bsel = s_;
      bval = v_;
      bwr = 1'b1;
      @(negedge clk_i);
      bwr = 1'b0;
      @(negedge clk_i);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rdb(8'hB8, 8'h00, 8'h80);
      rdb(8'hE6, 8'h00, 8'h00);
      wrb(8'hB8, 8'h00, 8'hFF);
      rdb(8'hB8, 8'h00, 8'hFF);
      chk({7'h0, pri}, 15'hFF);
      wrb(8'hB8, 8'h00, 8'h00);
      rdb(8'hB8, 8'h00, 8'h80);
      for (k = 0; k < 7; k = k + 1) begin
        bitw(k[2:0], 1'b1);
        chk({8'h0, lvl[6:0]}, 15'h1 << k);
        bitw(k[2:0], 1'b0);
      end
      wrb(8'hB8, 8'h01, 8'h7F);
      rdb(8'hB8, 8'h00, 8'h80);
      rdb(8'hB8, 8'h01, 8'h00);
      wrb(8'hE6, 8'h05, 8'h5A);
      rdb(8'hE6, 8'h02, 8'h5A);
      chk({7'h0, eie}, 15'h5A);
      rdb(8'h10, 8'h00, 8'h00);
      $display("test regs done");
    end
  endtask
  // each enable bit alone passes only its own source, both flags of pairs
  task t_mask;
    begin
      glob = 1'b1;
      pend = 15'h7FFF;
      for (a = 0; a < 2; a = a + 1) begin
        alt = a[0];
        for (k = 0; k < 8; k = k + 1) begin
          wrb(8'hE6, 8'h00, 8'h01 << k);
          @(negedge clk_i);
          chk(req, 15'h80 << k);
        end
      end
      glob = 1'b0;
      repeat (2) @(negedge clk_i);
      chk(req, 15'h0);
      chk({14'h0, sv}, 15'h0);
      $display("test mask done");
    end
  endtask
  task t_pick;
    begin
      glob = 1'b1;
      ben = 7'h7F;
      epri = 8'h80;
      pend = 15'h4001;
      wrb(8'hE6, 8'h00, 8'hFF);
      repeat (2) @(negedge clk_i);
      chk({sh, si}, 5'h1E);
      bitw(3'h0, 1'b1);
      @(negedge clk_i);
      chk({sh, si}, 5'h10);
      ben = 7'h7E;
      repeat (2) @(negedge clk_i);
      chk({sh, si, req[0]}, 6'h3C);
      chk({14'h0, sv}, 15'h1);
      $display("test pick done");
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // a hung run counts as a failure
  initial begin
    #200000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    t_regs;
    t_mask;
    t_pick;
    end_sim;
  end
endmodule // testbench
